// ### hdl/tchr_chan_decode.sv
`timescale 1ns/1ps
`default_nettype none

module tchr_chan_decode #(
    parameter int FUNCS = 16
) (
    input wire tchr_pkg::tchr_chan_s cfg,
    output logic [FUNCS-1:0] func_onehot,
    output logic want_low,
    output logic want_mid,
    output logic want_high
);

    logic wants_service;

    // Function code picks which time function reads the seq/req fields
    always_comb begin
        func_onehot = '0;
        func_onehot[cfg.func] = 1'b1;
    end

    // A nonzero request or a link bit asks for service
    assign wants_service = (cfg.req != tchr_pkg::FIELD_IDLE) || cfg.link;

    // Disabled channels never compete for a slot
    assign want_low = wants_service && (cfg.pri == tchr_pkg::PRI_LOW);
    assign want_mid = wants_service && (cfg.pri == tchr_pkg::PRI_MID);
    assign want_high = wants_service && (cfg.pri == tchr_pkg::PRI_HIGH);

endmodule

`default_nettype wire

// ### hdl/tchr_pkg.sv
package tchr_pkg;

    localparam int NCH = 16;
    localparam int CH_W = 4;
    localparam int FIELD_W = 2;
    localparam int FUNC_COUNT = 16;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;

    // Byte offsets within the block's window
    localparam logic [7:0] OFF_SEQ_HI = 8'h14;
    localparam logic [7:0] OFF_SEQ_LO = 8'h16;
    localparam logic [7:0] OFF_SRQ_HI = 8'h18;
    localparam logic [7:0] OFF_SRQ_LO = 8'h1a;
    localparam logic [7:0] OFF_PRI_HI = 8'h1c;
    localparam logic [7:0] OFF_PRI_LO = 8'h1e;
    localparam logic [7:0] OFF_CIS = 8'h20;
    localparam logic [7:0] OFF_LNK = 8'h22;
    localparam logic [7:0] OFF_GNT = 8'h24;
    localparam logic [7:0] OFF_DCN = 8'h26;

    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [31:0] RST_FIELDS = 32'h0000_0000;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
    localparam logic [1:0] FIELD_IDLE = 2'h0;

    typedef enum logic [1:0] {
        PRI_OFF = 2'b00,
        PRI_LOW = 2'b01,
        PRI_MID = 2'b10,
        PRI_HIGH = 2'b11
    } tchr_pri_e;

    // Seven-slot round: high 4, middle 2, low 1; slot 0 in the low bits
    localparam int SLOT_COUNT = 7;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [13:0] SLOT_TABLE = {PRI_HIGH, PRI_MID, PRI_HIGH, PRI_LOW, PRI_HIGH, PRI_MID, PRI_HIGH};

    typedef enum logic {
        SCH_IDLE = 1'b0,
        SCH_BUSY = 1'b1
    } tchr_sched_e;

    typedef struct packed {
        logic valid;
        logic [3:0] chan;
    } tchr_event_s;

    typedef struct packed {
        logic [3:0] func;
        logic [1:0] seq;
        logic [1:0] req;
        tchr_pri_e pri;
        logic link;
    } tchr_chan_s;

endpackage

// ### hdl/tchr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Holds a host-written two-bit sequence field per channel for the selected function.
// - Holds a host-written two-bit service request field per channel.
// - Clears a channel's request field to zero when its service completes.
// - Priority 00 off; 01, 10, 11 get 1, 2, 4 of 7 slots.
// - One interrupt status bit per channel; one means asserted.
// - One test-mode link bit per channel; one means link request asserted.
// - Four-bit function code per channel selects one of sixteen functions.
module tchr_regs #(
    parameter int NCH = tchr_pkg::NCH,
    parameter int FUNCS = tchr_pkg::FUNC_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [4*NCH-1:0] func_sel,
    input wire logic engine_ready,
    input wire tchr_pkg::tchr_event_s done,
    input wire logic [NCH-1:0] int_set,
    input wire logic [NCH-1:0] link_set,
    output tchr_pkg::tchr_event_s grant,
    output logic [2*NCH-1:0] seq_fields,
    output logic [2*NCH-1:0] req_fields,
    output logic [FUNCS*NCH-1:0] func_onehot,
    output logic [NCH-1:0] irq_status
);

    logic [31:0] seq_q, seq_d;
    logic [31:0] srq_q, srq_d;
    logic [31:0] pri_q, pri_d;
    logic [15:0] cis_q, cis_d;
    logic [15:0] lnk_q, lnk_d;
    logic [15:0] gnt_q, gnt_d;
    logic [15:0] dcn_q, dcn_d;
    logic [15:0] rdata_q, rdata_d;
    logic [2:0] slot_q, slot_d;
    tchr_pkg::tchr_sched_e state_q, state_d;
    tchr_pkg::tchr_event_s grant_q, grant_d;
    logic [NCH-1:0] want_low, want_mid, want_high;
    logic [NCH-1:0] cand;
    logic [1:0] slot_lvl;
    logic [3:0] pick;
    logic found;
    logic fire;
    logic [15:0] pick_onehot;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            tchr_pkg::tchr_chan_s cfg;
            assign cfg.func = func_sel[4*g +: 4];
            assign cfg.seq = seq_q[2*g +: 2];
            assign cfg.req = srq_q[2*g +: 2];
            assign cfg.pri = tchr_pkg::tchr_pri_e'(pri_q[2*g +: 2]);
            assign cfg.link = lnk_q[g];
            tchr_chan_decode #(
                .FUNCS(FUNCS)
            ) u_dec (
                .cfg(cfg),
                .func_onehot(func_onehot[FUNCS*g +: FUNCS]),
                .want_low(want_low[g]),
                .want_mid(want_mid[g]),
                .want_high(want_high[g])
            );
        end
    endgenerate

    // Slot level first; an idle slot falls back to high, middle, low
    assign slot_lvl = tchr_pkg::SLOT_TABLE[{slot_q, 1'b0} +: 2];

    always_comb begin
        cand = '0;
        case (slot_lvl)
            tchr_pkg::PRI_HIGH: cand = want_high;
            tchr_pkg::PRI_MID: cand = want_mid;
            tchr_pkg::PRI_LOW: cand = want_low;
            default: cand = '0;
        endcase
        if (cand == '0) begin
            if (want_high != '0) begin
                cand = want_high;
            end else if (want_mid != '0) begin
                cand = want_mid;
            end else begin
                cand = want_low;
            end
        end
    end

    // Lowest channel number wins within a level
    always_comb begin
        pick = 4'h0;
        found = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (cand[i]) begin
                pick = 4'(i);
                found = 1'b1;
            end
        end
    end

    assign fire = (state_q == tchr_pkg::SCH_IDLE) && engine_ready && found;

    always_comb begin
        pick_onehot = '0;
        pick_onehot[pick] = 1'b1;
    end

    always_comb begin
        state_d = state_q;
        slot_d = slot_q;
        grant_d = grant_q;
        grant_d.valid = 1'b0;
        case (state_q)
            tchr_pkg::SCH_IDLE: begin
                if (fire) begin
                    state_d = tchr_pkg::SCH_BUSY;
                    grant_d.valid = 1'b1;
                    grant_d.chan = pick;
                    slot_d = (slot_q == tchr_pkg::SLOT_LAST) ? tchr_pkg::SLOT_FIRST : slot_q + 3'h1;
                end
            end
            tchr_pkg::SCH_BUSY: begin
                if (done.valid) begin
                    state_d = tchr_pkg::SCH_IDLE;
                end
            end
            default: state_d = tchr_pkg::SCH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= tchr_pkg::SCH_IDLE;
            slot_q <= tchr_pkg::SLOT_FIRST;
            grant_q <= '0;
        end else begin
            state_q <= state_d;
            slot_q <= slot_d;
            grant_q <= grant_d;
        end
    end

    // Host fields: a host write in the completion cycle overrides the clear
    always_comb begin
        seq_d = seq_q;
        srq_d = srq_q;
        pri_d = pri_q;
        if (done.valid) begin
            srq_d[{done.chan, 1'b0} +: 2] = tchr_pkg::FIELD_IDLE;
        end
        if (wr && addr == tchr_pkg::OFF_SEQ_HI) begin
            seq_d[31:16] = wdata;
        end else if (wr && addr == tchr_pkg::OFF_SEQ_LO) begin
            seq_d[15:0] = wdata;
        end else if (wr && addr == tchr_pkg::OFF_SRQ_HI) begin
            srq_d[31:16] = wdata;
        end else if (wr && addr == tchr_pkg::OFF_SRQ_LO) begin
            srq_d[15:0] = wdata;
        end else if (wr && addr == tchr_pkg::OFF_PRI_HI) begin
            pri_d[31:16] = wdata;
        end else if (wr && addr == tchr_pkg::OFF_PRI_LO) begin
            pri_d[15:0] = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seq_q <= tchr_pkg::RST_FIELDS;
            srq_q <= tchr_pkg::RST_FIELDS;
            pri_q <= tchr_pkg::RST_FIELDS;
        end else begin
            seq_q <= seq_d;
            srq_q <= srq_d;
            pri_q <= pri_d;
        end
    end

    // Status bits: writing zero clears, hardware set wins the same cycle
    always_comb begin
        cis_d = cis_q;
        lnk_d = lnk_q;
        if (wr && addr == tchr_pkg::OFF_CIS) begin
            cis_d = cis_q & wdata;
        end
        cis_d = cis_d | int_set;
        if (done.valid) begin
            lnk_d[done.chan] = 1'b0;
        end
        if (wr && addr == tchr_pkg::OFF_LNK) begin
            lnk_d = wdata;
        end
        lnk_d = lnk_d | link_set;
    end

    // Test view of the scheduler; software may preload either register
    always_comb begin
        gnt_d = gnt_q;
        dcn_d = dcn_q;
        if (wr && addr == tchr_pkg::OFF_GNT) begin
            gnt_d = wdata;
        end
        if (wr && addr == tchr_pkg::OFF_DCN) begin
            dcn_d = wdata;
        end
        if (fire) begin
            gnt_d[pick] = 1'b1;
            dcn_d = pick_onehot;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cis_q <= tchr_pkg::RST_REG;
            lnk_q <= tchr_pkg::RST_REG;
            gnt_q <= tchr_pkg::RST_REG;
            dcn_q <= tchr_pkg::RST_REG;
        end else begin
            cis_q <= cis_d;
            lnk_q <= lnk_d;
            gnt_q <= gnt_d;
            dcn_q <= dcn_d;
        end
    end

    always_comb begin
        rdata_d = tchr_pkg::RD_UNMAPPED;
        if (!rd) begin
            rdata_d = tchr_pkg::RD_UNMAPPED;
        end else if (addr == tchr_pkg::OFF_SEQ_HI) begin
            rdata_d = seq_q[31:16];
        end else if (addr == tchr_pkg::OFF_SEQ_LO) begin
            rdata_d = seq_q[15:0];
        end else if (addr == tchr_pkg::OFF_SRQ_HI) begin
            rdata_d = srq_q[31:16];
        end else if (addr == tchr_pkg::OFF_SRQ_LO) begin
            rdata_d = srq_q[15:0];
        end else if (addr == tchr_pkg::OFF_PRI_HI) begin
            rdata_d = pri_q[31:16];
        end else if (addr == tchr_pkg::OFF_PRI_LO) begin
            rdata_d = pri_q[15:0];
        end else if (addr == tchr_pkg::OFF_CIS) begin
            rdata_d = cis_q;
        end else if (addr == tchr_pkg::OFF_LNK) begin
            rdata_d = lnk_q;
        end else if (addr == tchr_pkg::OFF_GNT) begin
            rdata_d = gnt_q;
        end else if (addr == tchr_pkg::OFF_DCN) begin
            rdata_d = dcn_q;
        end
    end

    // Zero outside read cycles so a stale value is never mistaken for data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= tchr_pkg::RST_REG;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign grant = grant_q;
    assign seq_fields = seq_q;
    assign req_fields = srq_q;
    assign irq_status = cis_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_grant_taken;
        fire ##1 (state_q == tchr_pkg::SCH_BUSY && grant_q.valid);
    endsequence

    sequence s_grant_ends;
        !grant_q.valid [*2];
    endsequence

    chk_seq_write_lo: assert property (
        wr && addr == tchr_pkg::OFF_SEQ_LO |=> seq_q[15:0] == $past(wdata))
        else $error("sequence field write lost");

    chk_req_holds: assert property (
        !wr && !done.valid |=> srq_q == $past(srq_q))
        else $error("request field changed without cause");

    chk_done_clears: assert property (
        done.valid && !(wr && (addr == tchr_pkg::OFF_SRQ_HI || addr == tchr_pkg::OFF_SRQ_LO))
        |=> srq_q[{$past(done.chan), 1'b0} +: 2] == tchr_pkg::FIELD_IDLE)
        else $error("completion did not clear request");

    chk_grant_priority: assert property (
        fire |-> pri_q[{pick, 1'b0} +: 2] != tchr_pkg::PRI_OFF)
        else $error("disabled channel granted");

    chk_grant_sequence: assert property (
        fire && !done.valid |-> s_grant_taken ##1 (state_q == tchr_pkg::SCH_BUSY) and s_grant_taken ##1 s_grant_ends)
        else $error("grant handshake wrong");

    chk_slot_advance: assert property (
        fire |=> slot_q == (($past(slot_q) == tchr_pkg::SLOT_LAST) ? tchr_pkg::SLOT_FIRST : $past(slot_q) + 3'h1))
        else $error("slot round did not advance");

    chk_int_sets: assert property (
        int_set != '0 |=> (cis_q & $past(int_set)) == $past(int_set))
        else $error("interrupt status set lost");

    chk_link_sets: assert property (
        link_set != '0 |=> (lnk_q & $past(link_set)) == $past(link_set))
        else $error("link bit set lost");

    chk_func_decode: assert property (
        func_onehot[func_sel[3:0]] && $onehot(func_onehot[FUNCS-1:0]))
        else $error("function decode wrong");

    chk_grant_latch: assert property (
        fire |=> gnt_q[$past(pick)] && dcn_q == $past(pick_onehot) && grant_q.chan == $past(pick))
        else $error("grant latch mismatch");

    chk_read_status: assert property (
        rd && addr == tchr_pkg::OFF_CIS |=> rdata == $past(cis_q))
        else $error("status read data wrong");

endmodule

`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end

module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [63:0] func_sel = 64'h0;
    logic engine_ready;
    tchr_pkg::tchr_event_s done;
    logic [15:0] int_set = 16'h0000;
    logic [15:0] link_set = 16'h0000;
    tchr_pkg::tchr_event_s grant;
    logic [31:0] seq_fields;
    logic [31:0] req_fields;
    logic [255:0] func_onehot;
    logic [15:0] irq_status;
    int err_total = 0;
    int comparisons = 0;
    logic [3:0] grants[$];
    logic [15:0] v;
    logic [7:0] offs [0:9] = '{tchr_pkg::OFF_SEQ_HI, tchr_pkg::OFF_SEQ_LO, tchr_pkg::OFF_SRQ_HI,
        tchr_pkg::OFF_SRQ_LO, tchr_pkg::OFF_PRI_HI, tchr_pkg::OFF_PRI_LO, tchr_pkg::OFF_CIS,
        tchr_pkg::OFF_LNK, tchr_pkg::OFF_GNT, tchr_pkg::OFF_DCN};

    tchr_regs i_tchr_regs (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .func_sel(func_sel), .engine_ready(engine_ready), .done(done),
        .int_set(int_set), .link_set(link_set), .grant(grant), .seq_fields(seq_fields),
        .req_fields(req_fields), .func_onehot(func_onehot), .irq_status(irq_status));

    tchr_engine_model #(.DELAY(4)) i_tchr_engine_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .grant(grant), .engine_ready(engine_ready), .done(done));

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (grant.valid === 1'b1) begin
            grants.push_back(grant.chan);
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [15:0] e);
        rd_reg(a, v);
        `CHK(v, e, "register read value")
    endtask

    // Host waits for the field to drop to zero before touching the channel again
    task automatic poll_zero(input logic [7:0] a);
        for (int k = 0; k < 60; k++) begin
            rd_reg(a, v);
            if (v === 16'h0000) break;
        end
        expect_reg(a, 16'h0000);
    endtask

    task automatic tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset;
        wr_reg(8'h28, 16'hffff);
        expect_reg(8'h28, tchr_pkg::RD_UNMAPPED);
        for (int i = 0; i < 10; i++) begin
            expect_reg(offs[i], tchr_pkg::RST_REG);
        end
        $display("test reset done");
    endtask

    task automatic t_rw;
        for (int i = 0; i < 10; i++) begin
            wr_reg(offs[i], 16'ha5c3 + 16'(i));
            // Interrupt status bits can only be cleared by software, never set
            expect_reg(offs[i], (i == 6) ? 16'h0000 : 16'ha5c3 + 16'(i));
            wr_reg(offs[i], 16'h0000);
        end
        wr_reg(tchr_pkg::OFF_SEQ_HI, 16'h1b2d);
        wr_reg(tchr_pkg::OFF_SEQ_LO, 16'he4f6);
        wr_reg(tchr_pkg::OFF_SRQ_HI, 16'h9c63);
        wr_reg(tchr_pkg::OFF_SRQ_LO, 16'h36c9);
        @(posedge ref_clk);
        `CHK(seq_fields, 32'h1b2de4f6, "sequence fields")
        `CHK(req_fields, 32'h9c6336c9, "request fields")
        wr_reg(tchr_pkg::OFF_SRQ_HI, 16'h0000);
        wr_reg(tchr_pkg::OFF_SRQ_LO, 16'h0000);
        $display("test read write done");
    endtask

    task automatic t_service;
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h0001);
        for (int c = 1; c < 4; c++) begin
            grants.delete();
            wr_reg(tchr_pkg::OFF_SRQ_LO, 16'(c));
            poll_zero(tchr_pkg::OFF_SRQ_LO);
            `CHK(grants.size(), 1, "one grant per request")
            `CHK(req_fields[1:0], tchr_pkg::FIELD_IDLE, "request field idle")
        end
        expect_reg(tchr_pkg::OFF_GNT, 16'h0001);
        expect_reg(tchr_pkg::OFF_DCN, 16'h0001);
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h0000);
        wr_reg(tchr_pkg::OFF_SRQ_LO, 16'h0004);
        repeat (20) @(posedge ref_clk);
        expect_reg(tchr_pkg::OFF_SRQ_LO, 16'h0004);
        wr_reg(tchr_pkg::OFF_SRQ_LO, 16'h0000);
        $display("test service done");
    endtask

    // Three grants so far put the round at slot 3 (low), then slot 4 (high)
    task automatic t_order;
        grants.delete();
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h000d);
        wr_reg(tchr_pkg::OFF_SRQ_LO, 16'h0005);
        poll_zero(tchr_pkg::OFF_SRQ_LO);
        `CHK(grants.size(), 2, "two grants")
        `CHK(grants[0], 4'h0, "low level served in its slot")
        `CHK(grants[1], 4'h1, "high level served next")
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h0000);
        $display("test priority order done");
    endtask

    task automatic t_status;
        @(posedge ref_clk);
        int_set <= 16'h0108;
        @(posedge ref_clk);
        int_set <= 16'h0000;
        expect_reg(tchr_pkg::OFF_CIS, 16'h0108);
        `CHK(irq_status, 16'h0108, "status output")
        wr_reg(tchr_pkg::OFF_CIS, 16'hfff7);
        expect_reg(tchr_pkg::OFF_CIS, 16'h0100);
        wr_reg(tchr_pkg::OFF_CIS, 16'h0000);
        expect_reg(tchr_pkg::OFF_CIS, 16'h0000);
        $display("test interrupt status done");
    endtask

    task automatic t_link;
        grants.delete();
        @(posedge ref_clk);
        link_set <= 16'h0020;
        @(posedge ref_clk);
        link_set <= 16'h0000;
        expect_reg(tchr_pkg::OFF_LNK, 16'h0020);
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h0400);
        poll_zero(tchr_pkg::OFF_LNK);
        `CHK(grants.size(), 1, "link grant count")
        `CHK(grants[0], 4'h5, "link grant channel")
        wr_reg(tchr_pkg::OFF_PRI_LO, 16'h0000);
        $display("test link done");
    endtask

    task automatic t_func;
        @(posedge ref_clk);
        func_sel <= 64'hfedcba9876543210;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 16; i++) begin
            `CHK(func_onehot[16*i +: 16], 16'h0001 << i, "function one-hot")
        end
        $display("test function decode done");
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_service();
        t_order();
        t_status();
        t_link();
        t_func();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire

// ### test/tchr_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module tchr_engine_model #(
    parameter int DELAY = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire tchr_pkg::tchr_event_s grant,
    output logic engine_ready,
    output var tchr_pkg::tchr_event_s done
);
    logic busy_q;
    logic [7:0] cnt_q;
    logic [3:0] chan_q;

    assign engine_ready = ~busy_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            chan_q <= 4'h0;
            done <= '0;
        end else begin
            done.valid <= 1'b0;
            // Channel toggles outside the pulse so a stale value never looks valid
            done.chan <= ~done.chan;
            if (grant.valid && !busy_q) begin
                busy_q <= 1'b1;
                chan_q <= grant.chan;
                cnt_q <= 8'(DELAY);
            end else if (busy_q) begin
                if (cnt_q == 8'h00) begin
                    done.valid <= 1'b1;
                    done.chan <= chan_q;
                    busy_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire
